// file: pmra_mgmt_regs.v
// Behaviour
// - Addresses 0 to 8 hold the basic and negotiation registers, 9-15 none.
// - Addresses 16 to 19 hold vendor registers and 20 to 31 are reserved.
// - Read-only bits are returned on reads and never changed by writes.
// - Override-gated bits can always be read whatever the override bit.
// - While the override bit 16.15 is zero, override-gated bits ignore writes.
// - With the override bit set, the next write updates override-gated bits.
// - The next write to an implemented register after the one setting the override bit clears it.
// - The manager sets the override bit first, then writes the new value.
// - Read/write bits are read and written with no condition.
// - Clear-only bits are always readable and only take written zeros.
// - Registers are sixteen bits, shifted most significant bit first.
// - A read of an unimplemented address returns all ones.
// - A write to an unimplemented address changes no register.
// - Preamble suppression bit 1.6 is override-gated and resets to zero.
`timescale 1ns/1ps
`include "pmra_regs.vh"

module pmra_mgmt_regs (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_mdc,
	input wire i_mdio,
	output reg o_mdio,
	output reg o_mdio_oe,
	output wire [15:0] o_basic_control,
	output wire [15:0] o_extended_control,
	output wire o_preamble_suppress
);

	// Frame engine states
	localparam ST_IDLE = 3'd0;
	localparam ST_SFD = 3'd1;
	localparam ST_HDR = 3'd2;
	localparam ST_TA = 3'd3;
	localparam ST_DATA = 3'd4;

	// Register file and frame state
	reg [15:0] mem [0:31];
	reg [2:0] state_r;
	reg [5:0] ones_r;
	reg [4:0] cnt_r;
	reg [11:0] hdr_r;
	reg [15:0] shift_r;
	reg act_r;
	reg rd_r;
	reg mdc_q_r;
	integer i;

	// Decoded fields and flags
	wire mdc_rise;
	wire [15:0] ext_ctrl;
	wire ovr;
	wire supp;
	wire [4:0] regad;
	wire [15:0] wdata;
	wire [11:0] hdr_full;

	// Implemented address decode
	function implemented;
		input [4:0] a;
		begin
			case (a)
				`PMRA_ADDR_BASIC_CTRL, `PMRA_ADDR_BASIC_STAT,
				`PMRA_ADDR_IDENT_A, `PMRA_ADDR_IDENT_B,
				`PMRA_ADDR_NEG_ADV, `PMRA_ADDR_PARTNER,
				`PMRA_ADDR_NEG_EXP, `PMRA_ADDR_NP_TX,
				`PMRA_ADDR_PARTNER_NP: implemented = 1'b1;
				`PMRA_ADDR_EXT_CTRL, `PMRA_ADDR_QPOLL,
				`PMRA_ADDR_TEN_MEG, `PMRA_ADDR_EXT2: implemented = 1'b1;
				default: implemented = 1'b0;
			endcase
		end
	endfunction

	// Reset value per address
	function [15:0] rst_val;
		input [4:0] a;
		begin
			case (a)
				`PMRA_ADDR_BASIC_CTRL: rst_val = `PMRA_RST_BASIC_CTRL;
				`PMRA_ADDR_BASIC_STAT: rst_val = `PMRA_RST_BASIC_STAT;
				`PMRA_ADDR_IDENT_A: rst_val = `PMRA_RST_IDENT_A;
				`PMRA_ADDR_IDENT_B: rst_val = `PMRA_RST_IDENT_B;
				`PMRA_ADDR_NEG_ADV: rst_val = `PMRA_RST_NEG_ADV;
				`PMRA_ADDR_PARTNER: rst_val = `PMRA_RST_PARTNER;
				`PMRA_ADDR_NEG_EXP: rst_val = `PMRA_RST_NEG_EXP;
				`PMRA_ADDR_NP_TX: rst_val = `PMRA_RST_NP_TX;
				`PMRA_ADDR_PARTNER_NP: rst_val = `PMRA_RST_PARTNER_NP;
				`PMRA_ADDR_EXT_CTRL: rst_val = `PMRA_RST_EXT_CTRL;
				`PMRA_ADDR_QPOLL: rst_val = `PMRA_RST_QPOLL;
				`PMRA_ADDR_TEN_MEG: rst_val = `PMRA_RST_TEN_MEG;
				`PMRA_ADDR_EXT2: rst_val = `PMRA_RST_EXT2;
				default: rst_val = `PMRA_RST_NONE;
			endcase
		end
	endfunction

	// Unconditional write mask
	function [15:0] rw_mask;
		input [4:0] a;
		begin
			case (a)
				`PMRA_ADDR_BASIC_CTRL: rw_mask = `PMRA_RW_BASIC_CTRL;
				`PMRA_ADDR_NEG_ADV: rw_mask = `PMRA_RW_NEG_ADV;
				`PMRA_ADDR_NP_TX: rw_mask = `PMRA_RW_NP_TX;
				`PMRA_ADDR_EXT_CTRL: rw_mask = `PMRA_RW_EXT_CTRL;
				`PMRA_ADDR_TEN_MEG: rw_mask = `PMRA_RW_TEN_MEG;
				`PMRA_ADDR_EXT2: rw_mask = `PMRA_RW_EXT2;
				default: rw_mask = `PMRA_MASK_NONE;
			endcase
		end
	endfunction

	// Override-gated mask
	function [15:0] cw_mask;
		input [4:0] a;
		begin
			case (a)
				`PMRA_ADDR_BASIC_STAT: cw_mask = `PMRA_CW_BASIC_STAT;
				`PMRA_ADDR_EXT_CTRL: cw_mask = `PMRA_CW_EXT_CTRL;
				default: cw_mask = `PMRA_MASK_NONE;
			endcase
		end
	endfunction

	// Clear-only mask
	function [15:0] w0_mask;
		input [4:0] a;
		begin
			case (a)
				`PMRA_ADDR_TEN_MEG: w0_mask = `PMRA_W0_TEN_MEG;
				default: w0_mask = `PMRA_MASK_NONE;
			endcase
		end
	endfunction

	// Merge written data into one register by bit class
	function [15:0] merge;
		input [4:0] a;
		input [15:0] old;
		input [15:0] d;
		input ov;
		reg [15:0] allow;
		begin
			// plain bits always; gated bits shut when override low
			// gated bits open when override high
			allow = rw_mask(a) | (ov ? cw_mask(a) : `PMRA_MASK_NONE);
			merge = (old & ~allow) | (d & allow);
			merge = merge & ~(w0_mask(a) & ~d);
		end
	endfunction

	// Edge, override and field decode
	assign mdc_rise = i_mdc & ~mdc_q_r;
	assign ext_ctrl = mem[`PMRA_ADDR_EXT_CTRL];
	assign ovr = ext_ctrl[`PMRA_OVR_BIT];
	assign supp = mem[`PMRA_ADDR_BASIC_STAT][`PMRA_PRE_SUPP_BIT];
	assign hdr_full = {hdr_r[10:0], i_mdio};
	assign regad = hdr_r[4:0];
	assign wdata = {shift_r[14:0], i_mdio};

	// Outputs straight from register flops
	assign o_basic_control = mem[`PMRA_ADDR_BASIC_CTRL];
	assign o_extended_control = ext_ctrl;
	assign o_preamble_suppress = supp;

	// Management clock edge detect
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			mdc_q_r <= 1'b0;
		end else begin
			mdc_q_r <= i_mdc;
		end
	end

	// Serial frame engine and register file
	always @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			// Idle frame state
			state_r <= ST_IDLE;
			ones_r <= 6'd0;
			cnt_r <= 5'd0;
			hdr_r <= 12'h000;
			shift_r <= 16'h0000;
			act_r <= 1'b0;
			rd_r <= 1'b0;
			o_mdio <= 1'b0;
			o_mdio_oe <= 1'b0;
			// Every word to its reset value
			for (i = 0; i < 32; i = i + 1) begin
				mem[i] <= rst_val(i[4:0]);
			end
		end else if (mdc_rise) begin
			// One step per management clock rise
			case (state_r)
				// Count preamble ones, wait for start
				ST_IDLE: begin
					o_mdio_oe <= 1'b0;
					// Saturating preamble count
					if (i_mdio) begin
						if (ones_r != `PMRA_PREAMBLE_ONES) begin
							ones_r <= ones_r + 6'd1;
						end
					end else begin
						// A zero ends the preamble
						ones_r <= 6'd0;
						if (supp || ones_r == `PMRA_PREAMBLE_ONES) begin
							state_r <= ST_SFD;
						end
					end
				end
				// Second start bit must be one
				ST_SFD: begin
					cnt_r <= 5'd0;
					state_r <= i_mdio ? ST_HDR : ST_IDLE;
				end
				// Op code, station and register address
				ST_HDR: begin
					// Shift in header bits
					hdr_r <= hdr_full;
					cnt_r <= cnt_r + 5'd1;
					if (cnt_r == `PMRA_HDR_BITS - 5'd1) begin
						cnt_r <= 5'd0;
						state_r <= ST_TA;
						// Decode op and address match
						rd_r <= (hdr_full[11:10] == `PMRA_OP_READ);
						act_r <= ((hdr_full[11:10] == `PMRA_OP_READ) ||
							(hdr_full[11:10] == `PMRA_OP_WRITE)) &&
							(hdr_full[9:5] ==
							ext_ctrl[`PMRA_PHYAD_HI:`PMRA_PHYAD_LO]);
						shift_r <= implemented(hdr_full[4:0]) ?
							mem[hdr_full[4:0]] : `PMRA_UNMAPPED_DATA;
					end
				end
				// Turnaround: release, then drive zero
				ST_TA: begin
					cnt_r <= cnt_r + 5'd1;
					// Second turnaround rise starts data
					if (cnt_r == 5'd1) begin
						cnt_r <= 5'd0;
						state_r <= ST_DATA;
						if (act_r && rd_r) begin
							o_mdio <= shift_r[15];
							shift_r <= {shift_r[14:0], 1'b0};
						end
					end else if (act_r && rd_r) begin
						// Second turnaround bit driven low
						o_mdio <= 1'b0;
						o_mdio_oe <= 1'b1;
					end
				end
				// Sixteen data bits
				ST_DATA: begin
					cnt_r <= cnt_r + 5'd1;
					// Shift read data out, write data in
					if (rd_r) begin
						o_mdio <= shift_r[15];
						shift_r <= {shift_r[14:0], 1'b0};
					end else begin
						shift_r <= wdata;
					end
					// Last data bit: release and commit
					if (cnt_r == `PMRA_DATA_BITS - 5'd1) begin
						cnt_r <= 5'd0;
						state_r <= ST_IDLE;
						o_mdio_oe <= 1'b0;
						if (act_r && !rd_r && implemented(regad)) begin
							mem[regad] <= merge(regad, mem[regad],
								wdata, ovr);
							if (regad == `PMRA_ADDR_EXT_CTRL) begin
								// set only from the clear state
								mem[regad][`PMRA_OVR_BIT] <=
									~ovr & wdata[`PMRA_OVR_BIT];
							end else if (ovr) begin
								mem[`PMRA_ADDR_EXT_CTRL][`PMRA_OVR_BIT] <=
									1'b0;
							end
						end
					end
				end
				// Unused codes fall back to idle
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // pmra_mgmt_regs

// file: pmra_regs.vh
`ifndef PMRA_REGS_VH
`define PMRA_REGS_VH

// Register addresses
`define PMRA_ADDR_BASIC_CTRL 5'h00
`define PMRA_ADDR_BASIC_STAT 5'h01
`define PMRA_ADDR_IDENT_A 5'h02
`define PMRA_ADDR_IDENT_B 5'h03
`define PMRA_ADDR_NEG_ADV 5'h04
`define PMRA_ADDR_PARTNER 5'h05
`define PMRA_ADDR_NEG_EXP 5'h06
`define PMRA_ADDR_NP_TX 5'h07
`define PMRA_ADDR_PARTNER_NP 5'h08
`define PMRA_ADDR_EXT_CTRL 5'h10
`define PMRA_ADDR_QPOLL 5'h11
`define PMRA_ADDR_TEN_MEG 5'h12
`define PMRA_ADDR_EXT2 5'h13

// Field positions
`define PMRA_OVR_BIT 15
`define PMRA_PRE_SUPP_BIT 6
`define PMRA_PHYAD_HI 10
`define PMRA_PHYAD_LO 6

// Reset values (identifier words are arbitrary)
`define PMRA_RST_BASIC_CTRL 16'h3000
`define PMRA_RST_BASIC_STAT 16'h7809
`define PMRA_RST_IDENT_A 16'h1234
`define PMRA_RST_IDENT_B 16'h5670
`define PMRA_RST_NEG_ADV 16'h01e1
`define PMRA_RST_PARTNER 16'h0000
`define PMRA_RST_NEG_EXP 16'h0004
`define PMRA_RST_NP_TX 16'h2001
`define PMRA_RST_PARTNER_NP 16'h0000
`define PMRA_RST_EXT_CTRL 16'h0000
`define PMRA_RST_QPOLL 16'h0000
`define PMRA_RST_TEN_MEG 16'h0032
`define PMRA_RST_EXT2 16'h0000
`define PMRA_RST_NONE 16'h0000
`define PMRA_UNMAPPED_DATA 16'hffff

// Plain read/write bit masks
`define PMRA_RW_BASIC_CTRL 16'hff80
`define PMRA_RW_NEG_ADV 16'hbfff
`define PMRA_RW_NP_TX 16'ha7ff
`define PMRA_RW_EXT_CTRL 16'h0005
`define PMRA_RW_TEN_MEG 16'h0003
`define PMRA_RW_EXT2 16'h00ff
// Override-gated bit masks
`define PMRA_CW_BASIC_STAT 16'h0040
`define PMRA_CW_EXT_CTRL 16'h07c0
// Clear-only bit masks
`define PMRA_W0_TEN_MEG 16'h0030
`define PMRA_MASK_NONE 16'h0000

// Frame timing
`define PMRA_PREAMBLE_ONES 6'd32
`define PMRA_HDR_BITS 5'd12
`define PMRA_DATA_BITS 5'd16
`define PMRA_OP_READ 2'b10
`define PMRA_OP_WRITE 2'b01

`endif

// file: pmra_mgmt_regs_asserts.sv
`timescale 1ns/1ps
module pmra_chk (
	input wire i_core_clk,
	input wire i_sys_rst,
	input wire i_mdc,
	input wire i_mdio,
	input wire o_mdio,
	input wire o_mdio_oe,
	input wire [15:0] o_basic_control,
	input wire [15:0] o_extended_control,
	input wire o_preamble_suppress
);
	reg [3:0] mh_r;
	wire near;
	// Clock rise seen within the last three edges
	always @(posedge i_core_clk) begin
		mh_r <= {mh_r[2:0], i_mdc};
	end
	assign near = |(mh_r[2:0] & ~mh_r[3:1]);
	default clocking dc @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	oe_rise_a: assert property ($rose(o_mdio_oe) |-> near && !o_mdio)
		else $error("drive start bad");
	oe_hold_a: assert property ($rose(o_mdio_oe) |-> o_mdio_oe [*8])
		else $error("drive too short");
	bit_time_a: assert property ($changed(o_mdio) && o_mdio_oe |-> near)
		else $error("data bit off clock");
	ctrl_ro_a: assert property ($stable(o_basic_control[6:0]))
		else $error("fixed control bits moved");
	ext_ro_a: assert property ($stable(o_extended_control & 16'h783a))
		else $error("fixed extended bits moved");
	addr_gate_a: assert property ($changed(o_extended_control[10:6])
		|-> $past(o_extended_control[15]))
		else $error("address changed ungated");
	supp_gate_a: assert property ($changed(o_preamble_suppress)
		|-> $past(o_extended_control[15]))
		else $error("suppress changed ungated");
	ovr_clear_a: assert property ($fell(o_extended_control[15]) |-> near)
		else $error("override cleared off frame");
	cover property ($rose(o_mdio_oe));
	cover property ($rose(o_preamble_suppress));
	cover property ($fell(o_extended_control[15]));
endmodule // pmra_chk
bind pmra_mgmt_regs pmra_chk u_chk (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_mdc(i_mdc), .i_mdio(i_mdio),
	.o_mdio(o_mdio), .o_mdio_oe(o_mdio_oe),
	.o_basic_control(o_basic_control),
	.o_extended_control(o_extended_control),
	.o_preamble_suppress(o_preamble_suppress));

// file: pmra_sta.sv
`timescale 1ns/1ps
module pmra_sta (
	input wire i_clk,
	input wire i_line,
	output reg o_mdc,
	output reg o_mdio,
	output reg o_mdio_oe
);
	// Idle: clock still, line released
	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b1;
		o_mdio_oe = 1'b0;
	end
	task xfer(input [1:0] op, input [4:0] pa, input [4:0] ra,
		input [15:0] wd, output [15:0] rd);
		reg [63:0] v;
		integer i;
		begin
			v = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
			for (i = 63; i >= 0; i = i - 1) begin
				@(negedge i_clk);
				o_mdc = 1'b0;
				o_mdio_oe = !(op == 2'b10 && i < 18);
				o_mdio = v[i];
				repeat (2) @(negedge i_clk);
				if (i < 16)
					rd[i] = i_line;
				o_mdc = 1'b1;
				@(negedge i_clk);
			end
			@(negedge i_clk);
			o_mdc = 1'b0;
			o_mdio_oe = 1'b0;
		end
	endtask
endmodule // pmra_sta

// file: pmra_tb.sv
`timescale 1ns/1ps
`include "pmra_regs.vh"
module testbench;
	reg i_core_clk = 1'b0;
	reg i_sys_rst = 1'b1;
	wire s_mdc, s_d, s_oe, u_d, u_oe, line, ps;
	wire [15:0] bc, ec;
	reg [15:0] m [0:31];
	reg [31:0] seed = 32'd53843;
	reg [31:0] r;
	reg [4:0] a;
	integer n_mismatch = 0;
	integer check_count = 0;
	integer k;
	integer oe_cnt = 0;
	// Shared data line with pull-up
	assign line = (u_oe === 1'b1) ? u_d : (s_oe ? s_d : 1'b1);
	always #20 i_core_clk = ~i_core_clk;
	// Count cycles the block drives the data line
	always @(posedge i_core_clk)
		if (u_oe === 1'b1)
			oe_cnt <= oe_cnt + 1;
	pmra_mgmt_regs uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
		.i_mdc(s_mdc), .i_mdio(line), .o_mdio(u_d), .o_mdio_oe(u_oe),
		.o_basic_control(bc), .o_extended_control(ec),
		.o_preamble_suppress(ps));
	pmra_sta sta (.i_clk(i_core_clk), .i_line(line), .o_mdc(s_mdc),
		.o_mdio(s_d), .o_mdio_oe(s_oe));
	function [31:0] rnd(input d);
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			rnd = seed;
		end
	endfunction
	// Mapped flag, plain, gated and clear-only masks
	function [48:0] msk(input [4:0] x);
		case (x)
		5'h00: msk = {1'b1, `PMRA_RW_BASIC_CTRL, 32'h0};
		5'h01: msk = {1'b1, 16'h0, `PMRA_CW_BASIC_STAT, 16'h0};
		5'h04: msk = {1'b1, `PMRA_RW_NEG_ADV, 32'h0};
		5'h07: msk = {1'b1, `PMRA_RW_NP_TX, 32'h0};
		5'h10: msk = {1'b1, `PMRA_RW_EXT_CTRL, `PMRA_CW_EXT_CTRL, 16'h0};
		5'h12: msk = {1'b1, `PMRA_RW_TEN_MEG, 16'h0, `PMRA_W0_TEN_MEG};
		5'h13: msk = {1'b1, `PMRA_RW_EXT2, 32'h0};
		default: msk = {x < 5'h09 || x[4:2] == 3'b100, 48'h0};
		endcase
	endfunction
	task chk(input [23:0] nm, input [15:0] s, input [15:0] e);
		begin
			check_count = check_count + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] %s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task op(input [1:0] o, input [4:0] p, input [4:0] ra, input [15:0] d);
		reg [15:0] rd, nv, cw;
		reg [48:0] x;
		reg hit, drv;
		integer oe0;
		begin
			oe0 = oe_cnt;
			drv = (o == `PMRA_OP_READ) && (p == m[16][10:6]);
			sta.xfer(o, p, ra, d, rd);
			repeat (3) @(negedge i_core_clk);
			x = msk(ra);
			hit = p == m[16][10:6] && x[48];
			if (o == `PMRA_OP_READ)
				chk("rd", rd, hit ? m[ra] : `PMRA_UNMAPPED_DATA);
			chk("drv", {15'h0, oe_cnt != oe0}, {15'h0, drv});
			if (o == `PMRA_OP_WRITE && hit) begin
				cw = m[16][15] ? x[31:16] : 16'h0;
				nv = (m[ra] & ~(x[47:32] | cw | x[15:0]))
					| (d & (x[47:32] | cw)) | (m[ra] & d & x[15:0]);
				if (ra == 5'h10)
					nv[15] = !m[16][15] && d[15];
				m[16][15] = 1'b0;
				m[ra] = nv;
			end
			chk("ctl", bc, m[0]);
			chk("ext", ec, m[16]);
			chk("sup", {15'h0, ps}, {15'h0, m[1][6]});
		end
	endtask
	task wr(input [4:0] ra, input [15:0] d);
		begin
			op(`PMRA_OP_WRITE, m[16][10:6], ra, d);
			op(`PMRA_OP_READ, m[16][10:6], ra, 16'h0);
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, n_mismatch);
			if (n_mismatch == 0 && check_count > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// Reset image, then corners, then random frames
	initial begin
		for (k = 0; k < 32; k = k + 1)
			m[k] = 16'h0;
		m[0] = `PMRA_RST_BASIC_CTRL;
		m[1] = `PMRA_RST_BASIC_STAT;
		m[2] = `PMRA_RST_IDENT_A;
		m[3] = `PMRA_RST_IDENT_B;
		m[4] = `PMRA_RST_NEG_ADV;
		m[6] = `PMRA_RST_NEG_EXP;
		m[7] = `PMRA_RST_NP_TX;
		m[18] = `PMRA_RST_TEN_MEG;
		repeat (10) @(negedge i_core_clk);
		i_sys_rst = 1'b0;
		repeat (2) @(negedge i_core_clk);
		for (k = 0; k < 32; k = k + 1)
			op(`PMRA_OP_READ, 5'h00, k[4:0], 16'h0);
		wr(5'h01, 16'hffff);
		wr(5'h10, 16'h8000);
		wr(5'h14, 16'h0000);
		wr(5'h01, 16'h0040);
		wr(5'h01, 16'h0000);
		wr(5'h12, 16'h0010);
		wr(5'h12, 16'h0030);
		wr(5'h12, 16'h0000);
		for (k = 0; k < 80; k = k + 1) begin
			r = rnd(1'b0);
			a = r[3] ? r[8:4] : {r[4], 2'b00, r[5], r[6]};
			op(r[11:10], r[12] ? m[16][10:6] : r[17:13], a, r[31:16]);
			op(`PMRA_OP_READ, m[16][10:6], a, 16'h0);
		end
		print_verdict;
	end
	// Hang guard
	initial begin
		repeat (80000) @(posedge i_core_clk);
		n_mismatch = n_mismatch + 1;
		print_verdict;
	end
endmodule // testbench
